// [rtl/fbpc_pkg.sv]
// Purpose: shared constants, types and decoders of the flash block guard
// Assumes: 64 KB array of 32-bit words, byte addressed from zero
// Notes:   one-hot codes for access kinds and erase sequencer states
package fbpc_pkg;

    // array geometry
    localparam int FLASH_BYTES = 65536;
    localparam int ADDR_W      = 16;
    localparam int WORD_W      = 32;
    localparam int ERASE_LSB   = 10;
    localparam int PROT_LSB    = 11;
    localparam int NUM_ERASE   = FLASH_BYTES >> ERASE_LSB;
    localparam int NUM_PROT    = FLASH_BYTES >> PROT_LSB;
    localparam int BLK_W       = ADDR_W - ERASE_LSB;
    localparam int UNIT_W      = ADDR_W - PROT_LSB;
    localparam int WIDX_W      = ADDR_W - 2;
    localparam int CNT_W       = ERASE_LSB - 2;
    localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffff_ffff;

    // register port
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] OFS_RO    = 8'h00;
    localparam logic [REG_AW-1:0] OFS_XO    = 8'h04;
    localparam logic [REG_AW-1:0] OFS_STAT  = 8'h08;
    localparam logic [REG_AW-1:0] OFS_MASK  = 8'h0c;
    localparam logic [REG_AW-1:0] OFS_STATE = 8'h10;
    localparam logic [NUM_PROT-1:0] RST_RO  = 32'h0000_0000;
    localparam logic [NUM_PROT-1:0] RST_XO  = 32'h0000_0000;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_BLK_LSB  = 8;

    // events and their status bits
    localparam int EVT_N       = 3;
    localparam int EVT_RD_VIOL = 0;
    localparam int EVT_WR_VIOL = 1;
    localparam int EVT_ER_DONE = 2;
    localparam logic [EVT_N-1:0] RST_STAT = 3'h0;
    localparam logic [EVT_N-1:0] RST_MASK = 3'h0;

    // access channels
    localparam int NUM_CH   = 5;
    localparam int CH_FETCH = 0;
    localparam int CH_CPU   = 1;
    localparam int CH_DBG   = 2;
    localparam int CH_PROG  = 3;
    localparam int CH_ERASE = 4;

    typedef enum logic [3:0] {
        FBPC_K_FETCH = 4'b0001,
        FBPC_K_DREAD = 4'b0010,
        FBPC_K_PROG  = 4'b0100,
        FBPC_K_ERASE = 4'b1000
    } fbpc_kind_t;

    typedef enum logic [1:0] {
        FBPC_IDLE  = 2'b01,
        FBPC_ERASE = 2'b10
    } fbpc_fsm_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } fbpc_req_t;

    typedef struct packed {
        logic              ok;
        logic              err;
        logic [WORD_W-1:0] data;
    } fbpc_rsp_t;

    typedef struct packed {
        fbpc_fsm_t                 fsm;
        logic [BLK_W-1:0]          er_blk;
        logic [CNT_W-1:0]          er_cnt;
        logic [NUM_PROT-1:0]       ro;
        logic [NUM_PROT-1:0]       xo;
        logic [WORD_W-1:0]         reg_rdata;
        fbpc_rsp_t [NUM_CH-1:0]    rsp;
    } fbpc_state_t;

    typedef struct packed {
        logic [EVT_N-1:0] stat;
        logic [EVT_N-1:0] mask;
    } fbpc_irq_state_t;

    // protection unit of a byte address
    function automatic logic [UNIT_W-1:0] unit_of(
        input logic [ADDR_W-1:0] addr);
        unit_of = addr[ADDR_W-1:PROT_LSB];
    endfunction : unit_of

    // erase block of a byte address
    function automatic logic [BLK_W-1:0] blk_of(
        input logic [ADDR_W-1:0] addr);
        blk_of = addr[ADDR_W-1:ERASE_LSB];
    endfunction : blk_of

    // word index of a byte address
    function automatic logic [WIDX_W-1:0] widx_of(
        input logic [ADDR_W-1:0] addr);
        widx_of = addr[ADDR_W-1:2];
    endfunction : widx_of

    // access kind carried by each channel
    function automatic fbpc_kind_t ch_kind(input int ch);
        case (ch)
            CH_FETCH: ch_kind = FBPC_K_FETCH;
            CH_CPU:   ch_kind = FBPC_K_DREAD;
            CH_DBG:   ch_kind = FBPC_K_DREAD;
            CH_PROG:  ch_kind = FBPC_K_PROG;
            default:  ch_kind = FBPC_K_ERASE;
        endcase
    endfunction : ch_kind

endpackage : fbpc_pkg

// [rtl/fbpc_access_check.sv]
// Purpose: decides whether one access may touch its protection unit
// Assumes: maps hold one bit per 2 KB unit
// Notes:   purely combinational; execute-only wins if both bits are set
module fbpc_access_check (
    input  logic [fbpc_pkg::NUM_PROT-1:0] i_ro_map,  // read-only units
    input  logic [fbpc_pkg::NUM_PROT-1:0] i_xo_map,  // execute-only units
    input  fbpc_pkg::fbpc_kind_t          i_kind,    // kind of access
    input  logic [fbpc_pkg::ADDR_W-1:0]   i_addr,    // flash byte address
    output logic                          o_allow    // access permitted
);

    logic [fbpc_pkg::UNIT_W-1:0] unit;
    logic                        ro;
    logic                        xo;

    // one setting covers both 1 KB halves of the unit
    assign unit = fbpc_pkg::unit_of(i_addr);  // [RQ4] [RQ10]
    assign ro   = i_ro_map[unit];
    assign xo   = i_xo_map[unit];

    // permission by kind and unit state
    always_comb begin
        case (i_kind)
            fbpc_pkg::FBPC_K_FETCH: o_allow = 1'b1;
            fbpc_pkg::FBPC_K_DREAD: o_allow = ~xo;      // [RQ8] [RQ5]
            fbpc_pkg::FBPC_K_PROG:  o_allow = ~(ro | xo); // [RQ6] [RQ7]
            fbpc_pkg::FBPC_K_ERASE: o_allow = ~(ro | xo); // [RQ6] [RQ7]
            default:                o_allow = 1'b0;
        endcase
    end

endmodule : fbpc_access_check

// [rtl/fbpc_irq.sv]
// Purpose: sticky event status, mask and one level interrupt
// Assumes: clear is write-one-to-clear, already decoded by the caller
// Notes:   an event in the clearing cycle stays set
module fbpc_irq (
    input  logic                       i_mclk,        // system clock
    input  logic                       i_srst,        // sync reset, high
    input  logic [fbpc_pkg::EVT_N-1:0] i_evt,         // event pulses
    input  logic [fbpc_pkg::EVT_N-1:0] i_clr,         // bits to clear
    input  logic                       i_mask_wr,     // mask write strobe
    input  logic [fbpc_pkg::EVT_N-1:0] i_mask_wdata,  // new mask
    output logic [fbpc_pkg::EVT_N-1:0] o_stat,        // sticky status
    output logic [fbpc_pkg::EVT_N-1:0] o_mask,        // mask register
    output logic                       o_irq          // level interrupt
);

    fbpc_pkg::fbpc_irq_state_t st_r;
    fbpc_pkg::fbpc_irq_state_t st_nxt;

    // set is or'd after the clear so a late event is never lost
    always_comb begin
        st_nxt      = st_r;
        st_nxt.stat = (st_r.stat & ~i_clr) | i_evt;
        if (i_mask_wr) begin
            st_nxt.mask = i_mask_wdata;
        end
    end

    // state register
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st_r <= '{stat: fbpc_pkg::RST_STAT, mask: fbpc_pkg::RST_MASK};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the registers
    assign o_stat = st_r.stat;
    assign o_mask = st_r.mask;
    assign o_irq  = |(st_r.stat & st_r.mask);

endmodule : fbpc_irq

// [rtl/fbpc_flash_guard.sv]
// Purpose: 64 KB flash array with per-unit protection on data reads, program and erase
// Assumes: one system clock; requesters sit on the same clock
// Notes:   erase walks one word per cycle; program only clears bits
//
// Notes on behaviour
// RQ1: the array holds 64 KB, split into 64 erase blocks.
// RQ2: each 1 KB block erases alone, leaving all other blocks intact.
// RQ3: a finished erase leaves every bit of that block at one.
// RQ4: pairs of erase blocks share one 2 KB protection setting.
// RQ5: each protection unit can be read-only or execute-only.
// RQ6: read-only units refuse erase and program, contents stay unchanged.
// RQ7: execute-only units also refuse erase and program.
// RQ8: execute-only units serve fetches only, deny processor and debugger reads.
// RQ9: a permitted read answers in the next single clock cycle.
// RQ10: erase block from address bits 10 up, unit from bits 11 up.
// RQ11: refusals raise a violation flag, denied reads return zero data; busy refusals and an erase losing to a program raise none.
module fbpc_flash_guard (
    input  logic                          i_mclk,      // system clock
    input  logic                          i_srst,      // sync reset, high
    input  logic [fbpc_pkg::REG_AW-1:0]   i_reg_addr,  // register offset
    input  logic [fbpc_pkg::WORD_W-1:0]   i_reg_wdata, // register wr data
    input  logic                          i_reg_wr,    // write strobe
    input  logic                          i_reg_rd,    // read strobe
    output logic [fbpc_pkg::WORD_W-1:0]   o_reg_rdata, // read data, +1
    input  fbpc_pkg::fbpc_req_t           i_fetch,     // instruction fetch
    input  fbpc_pkg::fbpc_req_t           i_cpu_rd,    // processor data rd
    input  fbpc_pkg::fbpc_req_t           i_dbg_rd,    // debugger data rd
    input  fbpc_pkg::fbpc_req_t           i_prog,      // program a word
    input  fbpc_pkg::fbpc_req_t           i_erase,     // erase a block
    output fbpc_pkg::fbpc_rsp_t           o_fetch,     // fetch answer
    output fbpc_pkg::fbpc_rsp_t           o_cpu_rd,    // processor answer
    output fbpc_pkg::fbpc_rsp_t           o_dbg_rd,    // debugger answer
    output fbpc_pkg::fbpc_rsp_t           o_prog,      // program answer
    output fbpc_pkg::fbpc_rsp_t           o_erase,     // erase answer
    output logic                          o_busy,      // erase running
    output logic                          o_irq        // interrupt level
);

    localparam fbpc_pkg::fbpc_state_t ST_RST = '{
        fsm:     fbpc_pkg::FBPC_IDLE,
        ro:      fbpc_pkg::RST_RO,
        xo:      fbpc_pkg::RST_XO,
        default: '0
    };

    fbpc_pkg::fbpc_state_t st_r;
    fbpc_pkg::fbpc_state_t st_nxt;

    // the array itself; flash has no reset, so words start unknown
    logic [fbpc_pkg::WORD_W-1:0] mem [fbpc_pkg::FLASH_BYTES/4];

    fbpc_pkg::fbpc_req_t         req      [fbpc_pkg::NUM_CH];
    logic [fbpc_pkg::WORD_W-1:0] rd_word  [fbpc_pkg::NUM_CH];
    logic [fbpc_pkg::NUM_CH-1:0] allow;
    logic                        idle;
    logic                        pg_go;
    logic                        er_go;
    logic                        er_last;
    logic                        mem_we;
    logic [fbpc_pkg::WIDX_W-1:0] mem_widx;
    logic [fbpc_pkg::WORD_W-1:0] mem_wdata;
    logic [fbpc_pkg::EVT_N-1:0]  evt;
    logic [fbpc_pkg::EVT_N-1:0]  irq_clr;
    logic                        irq_mask_wr;
    logic [fbpc_pkg::EVT_N-1:0]  irq_stat;
    logic [fbpc_pkg::EVT_N-1:0]  irq_mask;

    // channels gathered so the checks can be generated
    assign req[fbpc_pkg::CH_FETCH] = i_fetch;
    assign req[fbpc_pkg::CH_CPU]   = i_cpu_rd;
    assign req[fbpc_pkg::CH_DBG]   = i_dbg_rd;
    assign req[fbpc_pkg::CH_PROG]  = i_prog;
    assign req[fbpc_pkg::CH_ERASE] = i_erase;

    // one checker and one word lookup per channel
    for (genvar ch = 0; ch < fbpc_pkg::NUM_CH; ch++) begin : g_chk
        fbpc_access_check u_chk (
            .i_ro_map (st_r.ro),
            .i_xo_map (st_r.xo),
            .i_kind   (fbpc_pkg::ch_kind(ch)),
            .i_addr   (req[ch].addr),
            .o_allow  (allow[ch])
        );
        // word index spans the full 64 KB
        assign rd_word[ch] = mem[fbpc_pkg::widx_of(req[ch].addr)]; // [RQ1]
    end

    // acceptance of writes; program beats erase in the same cycle
    assign idle    = (st_r.fsm == fbpc_pkg::FBPC_IDLE);
    assign pg_go   = req[fbpc_pkg::CH_PROG].req & allow[fbpc_pkg::CH_PROG]
                     & idle;                                   // [RQ6] [RQ7]
    assign er_go   = req[fbpc_pkg::CH_ERASE].req & allow[fbpc_pkg::CH_ERASE]
                     & idle & ~pg_go;                          // [RQ6] [RQ7]
    assign er_last = (st_r.fsm == fbpc_pkg::FBPC_ERASE) & (&st_r.er_cnt);

    // array write port: erase fill or program and-in
    always_comb begin
        mem_we    = 1'b0;
        mem_widx  = fbpc_pkg::widx_of(req[fbpc_pkg::CH_PROG].addr);
        mem_wdata = rd_word[fbpc_pkg::CH_PROG]
                    & req[fbpc_pkg::CH_PROG].wdata;
        if (st_r.fsm == fbpc_pkg::FBPC_ERASE) begin
            mem_we    = 1'b1;
            mem_widx  = {st_r.er_blk, st_r.er_cnt};        // [RQ2]
            mem_wdata = fbpc_pkg::ERASED_WORD;             // [RQ3]
        end else if (pg_go) begin
            mem_we    = 1'b1;
        end
    end

    // array storage; kept out of the state struct on purpose
    always_ff @(posedge i_mclk) begin
        if (mem_we) begin
            mem[mem_widx] <= mem_wdata;
        end
    end

    // events for the status register
    always_comb begin
        evt = '0;
        evt[fbpc_pkg::EVT_RD_VIOL] =
            (req[fbpc_pkg::CH_CPU].req & ~allow[fbpc_pkg::CH_CPU]) |
            (req[fbpc_pkg::CH_DBG].req & ~allow[fbpc_pkg::CH_DBG]); // [RQ11]
        evt[fbpc_pkg::EVT_WR_VIOL] =
            (req[fbpc_pkg::CH_PROG].req & ~allow[fbpc_pkg::CH_PROG]) |
            (req[fbpc_pkg::CH_ERASE].req &
             ~allow[fbpc_pkg::CH_ERASE]);                           // [RQ11]
        evt[fbpc_pkg::EVT_ER_DONE] = er_last;
    end

    // status clear and mask write decode
    assign irq_clr     = (i_reg_wr && i_reg_addr == fbpc_pkg::OFS_STAT) ?
                         i_reg_wdata[fbpc_pkg::EVT_N-1:0] : '0;
    assign irq_mask_wr = i_reg_wr && (i_reg_addr == fbpc_pkg::OFS_MASK);

    fbpc_irq u_irq (
        .i_mclk       (i_mclk),
        .i_srst       (i_srst),
        .i_evt        (evt),
        .i_clr        (irq_clr),
        .i_mask_wr    (irq_mask_wr),
        .i_mask_wdata (i_reg_wdata[fbpc_pkg::EVT_N-1:0]),
        .o_stat       (irq_stat),
        .o_mask       (irq_mask),
        .o_irq        (o_irq)
    );

    // next state: answers, erase walk, registers
    always_comb begin
        st_nxt     = st_r;
        st_nxt.rsp = '0;
        // read channels: one cycle, zero data when denied
        for (int ch = fbpc_pkg::CH_FETCH; ch <= fbpc_pkg::CH_DBG; ch++) begin
            st_nxt.rsp[ch].ok   = req[ch].req & allow[ch];   // [RQ9] [RQ8]
            st_nxt.rsp[ch].err  = req[ch].req & ~allow[ch];  // [RQ11]
            st_nxt.rsp[ch].data = (req[ch].req & allow[ch]) ?
                                  rd_word[ch] : '0;          // [RQ11]
        end
        // program answers in the next cycle, busy also refuses
        st_nxt.rsp[fbpc_pkg::CH_PROG].ok  = pg_go;
        st_nxt.rsp[fbpc_pkg::CH_PROG].err =
            req[fbpc_pkg::CH_PROG].req & ~pg_go;
        st_nxt.rsp[fbpc_pkg::CH_ERASE].err =
            req[fbpc_pkg::CH_ERASE].req & ~er_go;
        // erase sequencer
        case (st_r.fsm)
            fbpc_pkg::FBPC_IDLE: begin
                if (er_go) begin
                    st_nxt.fsm    = fbpc_pkg::FBPC_ERASE;
                    st_nxt.er_blk = fbpc_pkg::blk_of(
                        req[fbpc_pkg::CH_ERASE].addr);   // [RQ10] [RQ2]
                    st_nxt.er_cnt = '0;
                end
            end
            fbpc_pkg::FBPC_ERASE: begin
                st_nxt.er_cnt = st_r.er_cnt
                                + {{(fbpc_pkg::CNT_W-1){1'b0}}, 1'b1};
                if (er_last) begin
                    st_nxt.fsm = fbpc_pkg::FBPC_IDLE;
                    st_nxt.rsp[fbpc_pkg::CH_ERASE].ok = 1'b1; // [RQ3]
                end
            end
            default: begin
                st_nxt.fsm = fbpc_pkg::FBPC_IDLE;
            end
        endcase
        // protection maps; software may set and clear freely
        if (i_reg_wr && i_reg_addr == fbpc_pkg::OFS_RO) begin
            st_nxt.ro = i_reg_wdata[fbpc_pkg::NUM_PROT-1:0];  // [RQ5]
        end
        if (i_reg_wr && i_reg_addr == fbpc_pkg::OFS_XO) begin
            st_nxt.xo = i_reg_wdata[fbpc_pkg::NUM_PROT-1:0];  // [RQ5]
        end
        // read data stands only in the cycle after the strobe
        st_nxt.reg_rdata = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                fbpc_pkg::OFS_RO:   st_nxt.reg_rdata = st_r.ro;
                fbpc_pkg::OFS_XO:   st_nxt.reg_rdata = st_r.xo;
                fbpc_pkg::OFS_STAT: st_nxt.reg_rdata = 32'(irq_stat);
                fbpc_pkg::OFS_MASK: st_nxt.reg_rdata = 32'(irq_mask);
                fbpc_pkg::OFS_STATE: begin
                    st_nxt.reg_rdata[fbpc_pkg::STATE_BUSY_BIT] = ~idle;
                    st_nxt.reg_rdata[fbpc_pkg::STATE_BLK_LSB +:
                                     fbpc_pkg::BLK_W] = st_r.er_blk;
                end
                default:            st_nxt.reg_rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state
    assign o_reg_rdata = st_r.reg_rdata;
    assign o_fetch     = st_r.rsp[fbpc_pkg::CH_FETCH];
    assign o_cpu_rd    = st_r.rsp[fbpc_pkg::CH_CPU];
    assign o_dbg_rd    = st_r.rsp[fbpc_pkg::CH_DBG];
    assign o_prog      = st_r.rsp[fbpc_pkg::CH_PROG];
    assign o_erase     = st_r.rsp[fbpc_pkg::CH_ERASE];
    assign o_busy      = ~idle;

    // fetches are never refused and carry the stored word
    property p_fetch_served;
        @(posedge i_mclk) disable iff (i_srst)
        i_fetch.req |=> o_fetch.ok && !o_fetch.err
                        && o_fetch.data == $past(rd_word[0]);
    endproperty
    a_fetch_served: assert property (p_fetch_served) // [RQ8] [RQ9]
        else $error("fetch not served with stored word");

    // execute-only blocks processor data reads and hides data
    property p_xo_cpu_deny;
        @(posedge i_mclk) disable iff (i_srst)
        i_cpu_rd.req && st_r.xo[fbpc_pkg::unit_of(i_cpu_rd.addr)]
        |=> o_cpu_rd.err && !o_cpu_rd.ok && o_cpu_rd.data == '0;
    endproperty
    a_xo_cpu_deny: assert property (p_xo_cpu_deny) // [RQ8] [RQ11]
        else $error("processor read of execute-only unit not denied");

    // execute-only blocks debugger reads, then flags a violation
    property p_xo_dbg_deny;
        @(posedge i_mclk) disable iff (i_srst)
        i_dbg_rd.req && st_r.xo[fbpc_pkg::unit_of(i_dbg_rd.addr)]
        |=> o_dbg_rd.err && o_dbg_rd.data == '0
            && irq_stat[fbpc_pkg::EVT_RD_VIOL];
    endproperty
    a_xo_dbg_deny: assert property (p_xo_dbg_deny) // [RQ8] [RQ11]
        else $error("debugger read of execute-only unit not denied");

    // permitted data read answers next cycle with the word
    property p_cpu_read;
        @(posedge i_mclk) disable iff (i_srst)
        i_cpu_rd.req && !st_r.xo[fbpc_pkg::unit_of(i_cpu_rd.addr)]
        |=> o_cpu_rd.ok && o_cpu_rd.data == $past(rd_word[1]);
    endproperty
    a_cpu_read: assert property (p_cpu_read) // [RQ9]
        else $error("permitted read not answered in one cycle");

    // program to a protected unit never writes the array
    property p_prog_protect;
        @(posedge i_mclk) disable iff (i_srst)
        i_prog.req && idle
        && (st_r.ro[fbpc_pkg::unit_of(i_prog.addr)]
            || st_r.xo[fbpc_pkg::unit_of(i_prog.addr)])
        |-> !mem_we ##1 o_prog.err && !o_prog.ok;
    endproperty
    a_prog_protect: assert property (p_prog_protect) // [RQ6] [RQ7]
        else $error("program reached a protected unit");

    // erase of a protected unit never starts
    property p_erase_protect;
        @(posedge i_mclk) disable iff (i_srst)
        i_erase.req && idle
        && (st_r.ro[fbpc_pkg::unit_of(i_erase.addr)]
            || st_r.xo[fbpc_pkg::unit_of(i_erase.addr)])
        |=> o_erase.err && !o_busy;
    endproperty
    a_erase_protect: assert property (p_erase_protect) // [RQ6] [RQ7]
        else $error("erase started on a protected unit");

    // accepted erase runs 256 busy cycles, then reports done
    property p_erase_len;
        @(posedge i_mclk) disable iff (i_srst)
        er_go |=> o_busy [*8] ##248 o_busy ##1 (o_erase.ok && !o_busy);
    endproperty
    a_erase_len: assert property (p_erase_len) // [RQ2] [RQ3]
        else $error("erase length or completion wrong");

    // erase writes only ones and only inside its own block
    property p_erase_fill;
        @(posedge i_mclk) disable iff (i_srst)
        o_busy |-> mem_we && mem_wdata == fbpc_pkg::ERASED_WORD
                   && mem_widx[fbpc_pkg::WIDX_W-1:fbpc_pkg::CNT_W]
                      == st_r.er_blk;
    endproperty
    a_erase_fill: assert property (p_erase_fill) // [RQ2] [RQ3]
        else $error("erase wrote outside its block or not ones");

    // masked-in write violation raises the interrupt next cycle
    property p_viol_irq;
        @(posedge i_mclk) disable iff (i_srst)
        evt[fbpc_pkg::EVT_WR_VIOL] && irq_mask[fbpc_pkg::EVT_WR_VIOL]
        && !irq_mask_wr |=> o_irq && irq_stat[fbpc_pkg::EVT_WR_VIOL];
    endproperty
    a_viol_irq: assert property (p_viol_irq) // [RQ11]
        else $error("write violation did not raise interrupt");

    // permitted debugger read answers next cycle with the word
    property p_dbg_read;
        @(posedge i_mclk) disable iff (i_srst)
        i_dbg_rd.req && !st_r.xo[fbpc_pkg::unit_of(i_dbg_rd.addr)]
        |=> o_dbg_rd.ok && o_dbg_rd.data == $past(rd_word[2]);
    endproperty
    a_dbg_read: assert property (p_dbg_read) // [RQ9]
        else $error("permitted debugger read not answered");

    // read-only units stay readable; only writes are refused
    property p_ro_readable;
        @(posedge i_mclk) disable iff (i_srst)
        i_cpu_rd.req && st_r.ro[fbpc_pkg::unit_of(i_cpu_rd.addr)]
        && !st_r.xo[fbpc_pkg::unit_of(i_cpu_rd.addr)]
        |=> o_cpu_rd.ok && !o_cpu_rd.err;
    endproperty
    a_ro_readable: assert property (p_ro_readable) // [RQ5] [RQ6]
        else $error("read of read-only unit refused");

    // no program lands while an erase walks its block
    property p_busy_refuse;
        @(posedge i_mclk) disable iff (i_srst)
        i_prog.req && o_busy
        |=> o_prog.err && !o_prog.ok;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) // [RQ2]
        else $error("program accepted during an erase");

endmodule : fbpc_flash_guard

// [testbench/fbpc_bus_model.sv]
// Purpose: requester model for fetch, data, program and erase ports
// Assumes: each port answers at the same edge that takes it, read 1 ns later
// Notes:   released ports carry inverted address and data, so stale
//          values are never mistaken for a live request
module fbpc_bus_model (
    input  logic                     i_mclk, // system clock
    output fbpc_pkg::fbpc_req_t [4:0] o_req, // requests by channel
    input  fbpc_pkg::fbpc_rsp_t [4:0] i_rsp  // answers by channel
);
    timeunit 1ns;
    timeprecision 1ns;

    // all ports idle from time zero
    initial o_req = '0;

    // one request held for one edge, answer taken in the next cycle
    task automatic issue(input int ch, input logic [15:0] a,
                         input logic [31:0] d,
                         output fbpc_pkg::fbpc_rsp_t r);
        @(posedge i_mclk);
        o_req[ch] <= '{1'b1, a, d};
        @(posedge i_mclk);
        o_req[ch] <= '{1'b0, ~a, ~d};
        #1 r = i_rsp[ch];
    endtask : issue
endmodule : fbpc_bus_model

// [testbench/fbpc_flash_guard_tb_top.sv]
// Purpose: self-checking bench of the protected flash guard
// Assumes: erase keeps busy 256 cycles, answers come one cycle late
// Notes:   the array is not reset, so blocks are erased before use
module fbpc_flash_guard_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      i_mclk      = 1'b0;
    logic                      i_srst      = 1'b1;
    logic [7:0]                i_reg_addr  = 8'h00;
    logic [31:0]               i_reg_wdata = 32'h0;
    logic                      i_reg_wr    = 1'b0;
    logic                      i_reg_rd    = 1'b0;
    logic [31:0]               o_reg_rdata;
    logic                      o_busy;
    logic                      o_irq;
    fbpc_pkg::fbpc_req_t [4:0] req;
    fbpc_pkg::fbpc_rsp_t [4:0] rsp;
    fbpc_pkg::fbpc_rsp_t       r;
    int                        error_cnt   = 0;
    int                        checks_done = 0;
    int                        seed        = 8394;
    int                        n;
    logic [31:0]               d;
    logic [31:0]               d2;
    localparam logic [33:0]    OKW = 34'h2_0000_0000;
    localparam logic [33:0]    ERR = 34'h1_0000_0000;

    always #4 i_mclk = ~i_mclk;

    // channels: 0 fetch, 1 cpu, 2 debugger, 3 program, 4 erase
    fbpc_flash_guard DUT (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_fetch(req[0]), .i_cpu_rd(req[1]),
        .i_dbg_rd(req[2]), .i_prog(req[3]), .i_erase(req[4]),
        .o_fetch(rsp[0]), .o_cpu_rd(rsp[1]), .o_dbg_rd(rsp[2]),
        .o_prog(rsp[3]), .o_erase(rsp[4]), .o_busy(o_busy), .o_irq(o_irq));
    fbpc_bus_model PM (.i_mclk(i_mclk), .o_req(req), .i_rsp(rsp));

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= v;
        @(posedge i_mclk);
        i_reg_wr    <= 1'b0;
        i_reg_wdata <= $random(seed);
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd   <= 1'b0;
        i_reg_addr <= 8'($random(seed));
        #1 chk({2'b00, o_reg_rdata}, {2'b00, e});
    endtask : rd

    task automatic acc(input int ch, input logic [15:0] a,
                       input logic [31:0] v, input logic [33:0] e);
        PM.issue(ch, a, v, r);
        chk(r, e);
    endtask : acc

    // bounded wait for the erase answer, counting busy cycles
    task automatic erase(input logic [15:0] a);
        acc(4, a, 32'h0, 34'h0);
        acc(3, a, 32'h0, ERR);
        n = 2; // the refused program above spans two busy cycles
        for (int i = 0; i < 300 && rsp[4].ok !== 1'b1; i++) begin
            n += int'(o_busy);
            @(posedge i_mclk);
            #1;
        end
        chk(34'(n), 34'd256);
        chk(rsp[4], OKW);
        if (rsp[4].ok !== 1'b1)
            final_report();
    endtask : erase

    initial begin
        repeat (8) @(posedge i_mclk);
        i_srst <= 1'b0;
        for (int a = 0; a <= 20; a += 4)
            rd(8'(a), 32'h0);
        erase(16'h0400);
        rd(8'h10, 32'h0000_0100);
        d = $random(seed);
        acc(3, 16'h0404, d, OKW);
        erase(16'h0000);
        acc(1, 16'h0404, 32'h0, OKW | d);
        repeat (20)
            acc(0, {6'h00, 8'($random(seed)), 2'b00}, 32'h0,
                OKW | 34'hffff_ffff);
        d2 = $random(seed);
        acc(3, 16'h0000, d2, OKW);
        acc(3, 16'h0000, d, OKW);
        acc(2, 16'h0000, 32'h0, OKW | (d & d2));
        wr(8'h00, 32'h1);
        acc(3, 16'h0404, 32'h0, ERR);
        acc(4, 16'h07fc, 32'h0, ERR);
        acc(1, 16'h0404, 32'h0, OKW | d);
        acc(3, 16'h0800, 32'h0, OKW);
        rd(8'h08, 32'h6);
        wr(8'h0c, 32'h2);
        chk(34'(o_irq), 34'h1);
        wr(8'h08, 32'h2);
        chk(34'(o_irq), 34'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        acc(0, 16'h0404, 32'h0, OKW | d);
        acc(1, 16'h0404, 32'h0, ERR);
        acc(2, 16'h07fc, 32'h0, ERR);
        acc(3, 16'h0000, 32'h0, ERR);
        acc(4, 16'h0000, 32'h0, ERR);
        acc(0, 16'h0000, 32'h0, OKW | (d & d2));
        rd(8'h08, 32'h7);
        final_report();
    end
endmodule : fbpc_flash_guard_tb_top
